// [rtl/pbio_consts.svh]
// Purpose: offsets, field positions, reset values and timing counts of the port block
// Assumes: 32-bit ahb-lite register bus, one word per register
// Notes: included by the port module and its checker
`ifndef PBIO_CONSTS_SVH
`define PBIO_CONSTS_SVH

`define PBIO_OFS_PIN_VALUE 12'h000
`define PBIO_OFS_OUT_LATCH 12'h004
`define PBIO_OFS_DIRECTION 12'h008
`define PBIO_OFS_MAIN_IRQ 12'h00c
`define PBIO_OFS_SECOND_IRQ 12'h010
`define PBIO_OFS_ALT_CTRL 12'h014
`define PBIO_OFS_IRQ_STATUS 12'h018
`define PBIO_OFS_IRQ_MASK 12'h01c

`define PBIO_BIT_PULLUP_DIS_N 7
`define PBIO_BIT_CHANGE_FLAG 0
`define PBIO_BIT_ALT_CMP 0
`define PBIO_BIT_ALT_PWM 1
`define PBIO_BIT_ALT_TRI 2
`define PBIO_BIT_ALT_CAN 3
`define PBIO_BIT_ST_CHANGE 0
`define PBIO_BIT_ST_PWM_SD 1

`define PBIO_RST_DIRECTION 8'hff
`define PBIO_RST_OUT_LATCH 8'h00
`define PBIO_RST_SECOND_IRQ 8'h80
`define PBIO_RST_ALT_CTRL 4'h0

`define PBIO_INSTR_CYCLE_NS 8
`define PBIO_CLK_PERIOD_NS 8
`define PBIO_INSTR_CYCLES ((`PBIO_INSTR_CYCLE_NS + `PBIO_CLK_PERIOD_NS - 1) / `PBIO_CLK_PERIOD_NS)

`endif

// [rtl/pbio_pkg.sv]
// Purpose: shared types of the port block
// Assumes: constants come from pbio_consts.svh
// Notes: types only
package pbio_pkg;
   typedef logic [7:0] pbio_byte_t;
   typedef logic [31:0] pbio_word_t;
   typedef logic [1:0] pbio_trans_t;
   typedef enum logic [1:0] {
      pbio_idle_t_val = 2'b01,
      pbio_data_t_val = 2'b10
   } pbio_phase_t;
endpackage : pbio_pkg

// [rtl/pbio_port.sv]
// Purpose: eight-pin bidirectional port with upper nibble change detect, on ahb-lite
// Assumes: one clock mclk at 125 MHz, async active-high reset, pins sampled through three flops
// Notes: one instruction cycle is taken as one mclk period
// Functional notes
// - eight pins, each usable as digital input or output.
// - direction 0 drives latch onto pin, 1 makes pin an input.
// - reading pin value register returns pin levels for input pins.
// - clearing shared bit 7 of second irq register enables all pull-ups.
// - pull-up forced off on any pin set as output.
// - pull-up control resets inactive, so pull-ups off after reset.
// - change detect on upper four pins only, and only when inputs.
// - each port read snapshots upper pins; inputs compared against snapshot.
// - mismatches ORed to set change flag at bit 0 of main irq register.
// - change condition drives a wake request out of low-power modes.
// - mismatch keeps setting flag; clearable one instruction cycle after read.
// - enabled comparator output drives its pin instead of latch data.
// - pwm pins go high impedance on shutdown when tri-state configured.
// - can select routes transmit to pin 2 and receive from pin 3.
`timescale 1ns/100ps
`include "pbio_consts.svh"

module pbio_port #(
   parameter int WIDTH = 8,
   parameter int INSTR_CYCLES = `PBIO_INSTR_CYCLES
) (
   // clock, reset, enable
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire pbio_pkg::pbio_trans_t htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire pbio_pkg::pbio_word_t hwdata,
   input wire logic hready,
   output pbio_pkg::pbio_word_t hrdata,
   output logic hreadyout,
   output logic hresp,
   // pins
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out,
   output logic [WIDTH-1:0] pin_oe,
   output logic [WIDTH-1:0] pullup_en,
   // alternate functions
   input wire logic comparator_one_out,
   input wire logic [3:0] pwm_out,
   input wire logic pwm_shutdown,
   input wire logic can_transmit_out,
   output logic can_receive_in,
   // events
   output logic irq,
   output logic wake_req
);
   import pbio_pkg::*;

   // bus state
   pbio_phase_t phase_ff;
   logic [11:0] addr_ff;
   logic write_ff;
   // registers
   logic [WIDTH-1:0] latch_ff;
   logic [WIDTH-1:0] dir_ff;
   logic pullup_dis_n_ff;
   logic [3:0] alt_ff;
   logic change_flag_ff;
   logic [1:0] irq_status_ff;
   logic [1:0] irq_mask_ff;
   logic [3:0] snap_ff;
   logic [7:0] hold_cnt_ff;
   logic pwm_sd_ff;
   pbio_word_t rdata_ff;
   // synchroniser stages
   logic [WIDTH-1:0] sync1_ff;
   logic [WIDTH-1:0] sync2_ff;
   logic [WIDTH-1:0] sync3_ff;
   logic [WIDTH-1:0] pin_lvl_ff;

   logic addr_phase;
   logic wr_en;
   logic rd_en;
   logic port_rd;
   logic port_access;
   logic [3:0] mismatch;
   logic change_any;
   logic [WIDTH-1:0] drive_val;
   logic [WIDTH-1:0] drive_en;
   logic [WIDTH-1:0] rd_pins;
   pbio_word_t nxt_rdata;
   // write decode and forwarded register values for a read right behind a write
   logic wr_latch;
   logic wr_dir;
   logic wr_second;
   logic wr_alt;
   logic wr_mask;
   logic wr_status;
   logic wr_main;
   logic [WIDTH-1:0] fwd_latch;
   logic [WIDTH-1:0] fwd_dir;
   logic fwd_pullup_dis_n;
   logic [3:0] fwd_alt;
   logic [1:0] fwd_mask;
   logic [1:0] fwd_status;
   logic fwd_flag;

   assign addr_phase = hsel && hready && htrans[1];
   assign wr_en = (phase_ff == pbio_data_t_val) && write_ff;
   assign rd_en = addr_phase && !hwrite;
   assign port_rd = rd_en && (haddr == `PBIO_OFS_PIN_VALUE);
   // a write to the pin value register or the latch also restarts the clear hold-off
   assign port_access = port_rd || (wr_en && (addr_ff == `PBIO_OFS_PIN_VALUE ||
                                              addr_ff == `PBIO_OFS_OUT_LATCH));

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_ff;

   // address phase capture; slave is zero wait state
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         phase_ff <= pbio_idle_t_val;
         addr_ff <= 12'h000;
         write_ff <= 1'b0;
      end else if (clk_en && hready) begin
         phase_ff <= addr_phase ? pbio_data_t_val : pbio_idle_t_val;
         addr_ff <= haddr;
         write_ff <= hwrite;
      end
   end

   // three-stage sampler; second and third must agree before a level counts
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         sync3_ff <= '0;
         pin_lvl_ff <= '0;
      end else if (clk_en) begin
         sync1_ff <= pin_in;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         for (int i = 0; i < WIDTH; i++) begin
            if (sync2_ff[i] == sync3_ff[i]) begin
               pin_lvl_ff[i] <= sync3_ff[i];
            end
         end
      end
   end

   // latch, direction, pull-up control, alternate select
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         latch_ff <= `PBIO_RST_OUT_LATCH;
         dir_ff <= `PBIO_RST_DIRECTION;
         pullup_dis_n_ff <= 1'b1;
         alt_ff <= `PBIO_RST_ALT_CTRL;
         irq_mask_ff <= 2'b00;
      end else if (clk_en && wr_en) begin
         if (addr_ff == `PBIO_OFS_PIN_VALUE || addr_ff == `PBIO_OFS_OUT_LATCH) begin
            latch_ff <= hwdata[WIDTH-1:0];
         end else if (addr_ff == `PBIO_OFS_DIRECTION) begin
            dir_ff <= hwdata[WIDTH-1:0];
         end else if (addr_ff == `PBIO_OFS_SECOND_IRQ) begin
            pullup_dis_n_ff <= hwdata[`PBIO_BIT_PULLUP_DIS_N];
         end else if (addr_ff == `PBIO_OFS_ALT_CTRL) begin
            alt_ff <= hwdata[3:0];
         end else if (addr_ff == `PBIO_OFS_IRQ_MASK) begin
            irq_mask_ff <= hwdata[1:0];
         end
      end
   end

   // per-pin compare of the upper nibble against the read snapshot
   generate
      for (genvar g = 0; g < 4; g++) begin : g_cmp
         assign mismatch[g] = dir_ff[g+4] && (pin_lvl_ff[g+4] != snap_ff[g]);
      end
   endgenerate
   assign change_any = |mismatch;
   assign wake_req = change_any;

   // snapshot on each pin value read; blanking counter holds off the clear for one cycle
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         snap_ff <= 4'h0;
         hold_cnt_ff <= 8'h00;
      end else if (clk_en) begin
         if (port_rd) begin
            snap_ff <= pin_lvl_ff[7:4];
         end
         if (port_access) begin
            hold_cnt_ff <= 8'(INSTR_CYCLES);
         end else if (hold_cnt_ff != 8'h00) begin
            hold_cnt_ff <= hold_cnt_ff - 8'h01;
         end
      end
   end

   // change flag: set wins over clear, clear refused during the hold-off
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         change_flag_ff <= 1'b0;
      end else if (clk_en) begin
         if (change_any) begin
            change_flag_ff <= 1'b1;
         end else if (wr_en && addr_ff == `PBIO_OFS_MAIN_IRQ && hold_cnt_ff == 8'h00 &&
                      !hwdata[`PBIO_BIT_CHANGE_FLAG]) begin
            change_flag_ff <= 1'b0;
         end
      end
   end

   // sticky status, write one to clear, set wins
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_status_ff <= 2'b00;
         pwm_sd_ff <= 1'b0;
      end else if (clk_en) begin
         pwm_sd_ff <= pwm_shutdown;
         for (int i = 0; i < 2; i++) begin
            if (wr_en && addr_ff == `PBIO_OFS_IRQ_STATUS && hwdata[i]) begin
               irq_status_ff[i] <= 1'b0;
            end
         end
         if (change_any) begin
            irq_status_ff[`PBIO_BIT_ST_CHANGE] <= 1'b1;
         end
         if (pwm_shutdown && !pwm_sd_ff) begin
            irq_status_ff[`PBIO_BIT_ST_PWM_SD] <= 1'b1;
         end
      end
   end
   assign irq = |(irq_status_ff & irq_mask_ff);

   // pin drive with alternate function priority
   always_comb begin
      drive_val = latch_ff;
      drive_en = ~dir_ff;
      if (alt_ff[`PBIO_BIT_ALT_PWM]) begin
         drive_val[4] = pwm_out[0];
         drive_val[3:1] = pwm_out[3:1];
         if (pwm_shutdown && alt_ff[`PBIO_BIT_ALT_TRI]) begin
            drive_en[4] = 1'b0;
            drive_en[3:1] = 3'b000;
         end
      end
      if (alt_ff[`PBIO_BIT_ALT_CMP]) begin
         drive_val[2] = comparator_one_out;
      end
      if (alt_ff[`PBIO_BIT_ALT_CAN]) begin
         drive_val[2] = can_transmit_out;
         drive_en[2] = 1'b1;
         drive_en[3] = 1'b0;
      end
   end

   assign pin_out = drive_val;
   assign pin_oe = drive_en;
   // a pin forced to drive by an alternate function loses its pull-up as well
   assign pullup_en = {WIDTH{~pullup_dis_n_ff}} & dir_ff & ~drive_en;
   assign can_receive_in = alt_ff[`PBIO_BIT_ALT_CAN] ? pin_lvl_ff[3] : 1'b1;

   // data-phase write decode; the latch is reached through both the pin value and the latch offsets
   always_comb begin
      wr_latch = 1'b0;
      wr_dir = 1'b0;
      wr_second = 1'b0;
      wr_alt = 1'b0;
      wr_mask = 1'b0;
      wr_status = 1'b0;
      wr_main = 1'b0;
      if (wr_en) begin
         if (addr_ff == `PBIO_OFS_PIN_VALUE || addr_ff == `PBIO_OFS_OUT_LATCH) begin
            wr_latch = 1'b1;
         end else if (addr_ff == `PBIO_OFS_DIRECTION) begin
            wr_dir = 1'b1;
         end else if (addr_ff == `PBIO_OFS_SECOND_IRQ) begin
            wr_second = 1'b1;
         end else if (addr_ff == `PBIO_OFS_ALT_CTRL) begin
            wr_alt = 1'b1;
         end else if (addr_ff == `PBIO_OFS_IRQ_MASK) begin
            wr_mask = 1'b1;
         end else if (addr_ff == `PBIO_OFS_IRQ_STATUS) begin
            wr_status = 1'b1;
         end else if (addr_ff == `PBIO_OFS_MAIN_IRQ) begin
            wr_main = 1'b1;
         end
      end
   end

   // a read taken while a write is still in its data phase sees the written value, not the old one
   always_comb begin
      fwd_latch = latch_ff;
      fwd_dir = dir_ff;
      fwd_pullup_dis_n = pullup_dis_n_ff;
      fwd_alt = alt_ff;
      fwd_mask = irq_mask_ff;
      fwd_status = irq_status_ff;
      fwd_flag = change_flag_ff;
      if (wr_latch) begin
         fwd_latch = hwdata[WIDTH-1:0];
      end
      if (wr_dir) begin
         fwd_dir = hwdata[WIDTH-1:0];
      end
      if (wr_second) begin
         fwd_pullup_dis_n = hwdata[`PBIO_BIT_PULLUP_DIS_N];
      end
      if (wr_alt) begin
         fwd_alt = hwdata[3:0];
      end
      if (wr_mask) begin
         fwd_mask = hwdata[1:0];
      end
      // a status bit set in the same cycle shows on the following read
      if (wr_status) begin
         fwd_status = irq_status_ff & ~hwdata[1:0];
      end
      if (wr_main && !change_any && hold_cnt_ff == 8'h00 && !hwdata[`PBIO_BIT_CHANGE_FLAG]) begin
         fwd_flag = 1'b0;
      end
   end

   // input pins read the pin, output pins read the latch
   assign rd_pins = (pin_lvl_ff & fwd_dir) | (fwd_latch & ~fwd_dir);

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (haddr == `PBIO_OFS_PIN_VALUE) begin
         nxt_rdata[WIDTH-1:0] = rd_pins;
      end else if (haddr == `PBIO_OFS_OUT_LATCH) begin
         nxt_rdata[WIDTH-1:0] = fwd_latch;
      end else if (haddr == `PBIO_OFS_DIRECTION) begin
         nxt_rdata[WIDTH-1:0] = fwd_dir;
      end else if (haddr == `PBIO_OFS_MAIN_IRQ) begin
         nxt_rdata[`PBIO_BIT_CHANGE_FLAG] = fwd_flag;
      end else if (haddr == `PBIO_OFS_SECOND_IRQ) begin
         nxt_rdata[`PBIO_BIT_PULLUP_DIS_N] = fwd_pullup_dis_n;
      end else if (haddr == `PBIO_OFS_ALT_CTRL) begin
         nxt_rdata[3:0] = fwd_alt;
      end else if (haddr == `PBIO_OFS_IRQ_STATUS) begin
         nxt_rdata[1:0] = fwd_status;
      end else if (haddr == `PBIO_OFS_IRQ_MASK) begin
         nxt_rdata[1:0] = fwd_mask;
      end
   end

   // read data captured at the address phase, stands in the data phase
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_ff <= 32'h0000_0000;
      end else if (clk_en && rd_en) begin
         rdata_ff <= nxt_rdata;
      end
   end

endmodule : pbio_port

// [dv/pbio_monitor.sv]
// Purpose: port-level checks of the port block
// Assumes: single mclk domain, top ports only
// Notes: bound to pbio_port below
`timescale 1ns/100ps
`include "pbio_consts.svh"
module pbio_monitor #(
   parameter int WIDTH = 8
) (
   // clock, reset
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // bus
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire pbio_pkg::pbio_trans_t htrans,
   input wire logic hwrite,
   input wire pbio_pkg::pbio_word_t hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // pins, events
   input wire logic [WIDTH-1:0] pin_out,
   input wire logic [WIDTH-1:0] pin_oe,
   input wire logic [WIDTH-1:0] pullup_en,
   input wire logic irq,
   input wire logic wake_req
);
   import pbio_pkg::*;
   logic wr_ff;
   logic up_ff;
   logic [11:0] adr_ff;
   // marks the data phase of a taken write
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ff <= 1'b0;
         adr_ff <= 12'h000;
      end else if (clk_en) begin
         wr_ff <= hsel && hready && htrans[1] && hwrite;
         adr_ff <= haddr;
      end
   end
   // low only up to the first edge after release
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) up_ff <= 1'b0;
      else up_ff <= 1'b1;
   end
   default clocking dcb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready-okay");
   a_reset_idle: assert property (!up_ff |-> pin_oe == '0 && pullup_en == '0 && !irq && !wake_req)
      else $error("outputs not idle after reset");
   a_dir_sets_oe: assert property (wr_ff && clk_en && adr_ff == `PBIO_OFS_DIRECTION
      |=> pin_oe[7:5] == ~$past(hwdata[7:5])) else $error("direction not on pin_oe");
   a_latch_sets_out: assert property (wr_ff && clk_en && (adr_ff == `PBIO_OFS_OUT_LATCH
      || adr_ff == `PBIO_OFS_PIN_VALUE) |=> pin_out[7:5] == $past(hwdata[7:5])) else $error("latch not on pin_out");
   a_pullup_off_out: assert property ((pullup_en & pin_oe) == '0) else $error("pull-up on output pin");
   a_pullup_shared: assert property (wr_ff && clk_en && adr_ff == `PBIO_OFS_SECOND_IRQ
      |=> pullup_en[7:5] == ($past(hwdata[7]) ? 3'b000 : ~pin_oe[7:5])) else $error("pull-up control wrong");
   a_mask_quiets: assert property (wr_ff && clk_en && adr_ff == `PBIO_OFS_IRQ_MASK && hwdata[7:0] == 8'h00
      |=> !irq[*2]) else $error("irq with all masked");
   a_wake_input: assert property (wake_req |-> pin_oe[7:4] != 4'hf) else $error("wake with no input pin");
   c_wake: cover property (wake_req && irq);
   c_pullups: cover property (pullup_en != '0);
   c_dir_write: cover property (wr_ff && adr_ff == `PBIO_OFS_DIRECTION);
endmodule : pbio_monitor

bind pbio_port pbio_monitor #(.WIDTH(WIDTH)) u_mon (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
   .irq(irq), .wake_req(wake_req));

// [dv/pbio_board.sv]
// Purpose: board wiring on the eight port pins
// Assumes: device wins where it drives
// Notes: an unheld pin without pull-up wanders each cycle
`timescale 1ns/100ps
module pbio_board (
   // clock
   input wire logic mclk,
   // device side
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] pullup_en,
   // board drive
   input wire logic [7:0] drv_val,
   input wire logic [7:0] drv_en,
   output logic [7:0] pin_in
);
   logic [7:0] float_ff = 8'h00;
   // so no check can lean on a stale level
   always @(posedge mclk) float_ff <= ~float_ff;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe[i]) pin_in[i] = pin_out[i];
         else if (drv_en[i]) pin_in[i] = drv_val[i];
         else if (pullup_en[i]) pin_in[i] = 1'b1;
         else pin_in[i] = float_ff[i];
      end
   end
endmodule : pbio_board

// [dv/tb.sv]
// Purpose: register-level tests of the port block
// Assumes: zero-wait bus, pins seen 4 edges late
// Notes: clk_en dropped once to check the freeze
`timescale 1ns/100ps
module tb;
   import pbio_pkg::*;
   logic mclk = 1'b0, sys_rst = 1'b1, hsel = 1'b1, hwrite = 1'b0, cmp = 1'b0, can_tx = 1'b1, pwm_sd = 1'b0;
   logic clk_en = 1'b1;
   logic [3:0] pwm = 4'h1;
   logic [11:0] haddr = 12'h000;
   pbio_trans_t htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   pbio_word_t hwdata = '0, hrdata, rd_v;
   logic hreadyout, hresp, can_rx, irq, wake_req;
   logic [7:0] pin_in, pin_out, pin_oe, pullup_en, drv_val = 8'h06, drv_en = 8'hff;
   int error_cnt = 0, checked = 0;
   always #4 mclk = ~mclk;
   pbio_port dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
      .comparator_one_out(cmp), .pwm_out(pwm), .pwm_shutdown(pwm_sd), .can_transmit_out(can_tx),
      .can_receive_in(can_rx), .irq(irq), .wake_req(wake_req));
   pbio_board board (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
      .drv_val(drv_val), .drv_en(drv_en), .pin_in(pin_in));
   task automatic chk(input pbio_word_t got, input pbio_word_t exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic xfer(input logic [11:0] a, input logic w, input pbio_word_t d);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd_v = hrdata;
   endtask : xfer
   task automatic rd(input logic [11:0] a, input pbio_word_t exp);
      xfer(a, 1'b0, '0);
      chk(rd_v, exp);
   endtask : rd
   task automatic report_and_stop();
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (20) @(posedge mclk);
      sys_rst <= 1'b0;
      rd(12'h008, 32'hff);
      rd(12'h010, 32'h80);
      rd(12'h020, 32'h0);
      $display("reset test done");
      xfer(12'h004, 1'b1, 32'ha5);
      xfer(12'h008, 1'b1, 32'h0f);
      repeat (6) @(posedge mclk);
      chk({pin_oe, pin_out}, 32'hf0a5);
      rd(12'h000, 32'ha6);
      drv_en <= 8'hf0;
      xfer(12'h010, 1'b1, 32'h0);
      repeat (6) @(posedge mclk);
      chk(32'(pullup_en), 32'h0f);
      rd(12'h000, 32'haf);
      xfer(12'h010, 1'b1, 32'h80);
      drv_en <= 8'hff;
      @(posedge mclk);
      chk(32'(pullup_en), 32'h0);
      $display("pin test done");
      drv_val <= 8'h00;
      xfer(12'h008, 1'b1, 32'h3f);
      xfer(12'h01c, 1'b1, 32'h1);
      repeat (6) @(posedge mclk);
      rd(12'h000, 32'h80);
      // one idle cycle before clearing, no polling meanwhile
      @(posedge mclk);
      xfer(12'h00c, 1'b1, 32'h0);
      xfer(12'h018, 1'b1, 32'h3);
      xfer(12'h004, 1'b1, 32'h25);
      repeat (6) @(posedge mclk);
      chk({wake_req, irq}, 32'h0);
      for (int i = 4; i < 6; i++) begin
         drv_val <= 8'h01 << i;
         repeat (6) @(posedge mclk);
         chk({wake_req, irq}, 32'h3);
         xfer(12'h00c, 1'b1, 32'h0);
         rd(12'h00c, 32'h1);
         xfer(12'h01c, 1'b1, 32'h0);
         @(posedge mclk);
         chk(32'(irq), 32'h0);
         xfer(12'h01c, 1'b1, 32'h1);
         rd(12'h000, 32'(8'h01 << i));
         @(posedge mclk);
         xfer(12'h00c, 1'b1, 32'h0);
         xfer(12'h018, 1'b1, 32'h1);
         rd(12'h00c, 32'h0);
         chk({wake_req, irq}, 32'h0);
      end
      $display("change test done");
      // frozen while clk_en is low: this write must not land
      clk_en <= 1'b0;
      xfer(12'h004, 1'b1, 32'h5a);
      clk_en <= 1'b1;
      rd(12'h004, 32'h25);
      xfer(12'h000, 1'b1, 32'h3c);
      rd(12'h004, 32'h3c);
      $display("freeze test done");
      xfer(12'h008, 1'b1, 32'h08);
      xfer(12'h004, 1'b1, 32'h04);
      xfer(12'h014, 1'b1, 32'h1);
      @(posedge mclk);
      chk(32'(pin_out[2]), 32'h0);
      xfer(12'h014, 1'b1, 32'h9);
      repeat (6) @(posedge mclk);
      chk({pin_out[2], can_rx}, 32'h2);
      xfer(12'h014, 1'b1, 32'h2);
      @(posedge mclk);
      chk({pin_oe[4], pin_out[4]}, 32'h3);
      pwm_sd <= 1'b1;
      xfer(12'h014, 1'b1, 32'h6);
      repeat (4) @(posedge mclk);
      chk(32'(pin_oe[4]), 32'h0);
      rd(12'h018, 32'h2);
      $display("alt test done");
      report_and_stop();
   end
   initial begin
      repeat (3000) @(posedge mclk);
      error_cnt++;
      report_and_stop();
   end
endmodule : tb
